// file: src/cwg_top.sv
/*
  Complementary waveform generator: register file, source select, shutdown
  logic, two dead-band delays and the A/B output stage.
  Assumes the register master follows the plain strobe port; source,
  comparator, logic cell and fault inputs are asynchronous to mclk.
*/
// Operation
// - Module on bit enables the generator; clear disables it.
// - Output B pin enable routes B waveform to its pin.
// - Output A pin enable routes A waveform to its pin.
// - Per-output invert bits flip polarity of A and B.
// - Clock select picks fast internal oscillator or system clock.
// - Shutdown level 11 drives pin high, 10 low, ignoring polarity.
// - Level 01 floats the pin; 00 gives polarity-applied inactive level.
// - Source register holds B level in bits 7-6, A in 5-4.
// - Three-bit source field selects logic cell, NCO, PWMs or comparators.
// - Shutdown status reads one after a shutdown; software may set it.
// - Auto-restart bit selects automatic restart; else software restarts.
// - Bit 3 enables comparator shutdown on high; cmp2 input used here.
// - Bit 2 enables shutdown on comparator 1 high.
// - Bit 1 enables shutdown on low fault input.
// - Bit 0 enables shutdown on logic cell 2 high.
// - Rising dead-band count in bits 5-0 delays A after B off.
// - Falling dead-band count in bits 5-0 delays B after A off.
// - Nonzero code N gives N to N+1 generator clocks delay.
// - Zero code bypasses dead-band for that edge.
// - Unimplemented bits read zero and ignore writes.
// - Control bits clear on reset; levels and counts keep values.
// - Rising input edge turns B off now, A on after delay.
// - Falling input edge turns A off now, B on after delay.
// - Auto-restart clears status when enabled shutdown sources inactive; override to next rise.
// - Without auto-restart software clears status; stays set while active.
`include "cwg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cwg_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var logic [7:0] reg_rdata,
  // Input sources
  input wire logic logic_cell1_out,
  input wire logic nco_out,
  input wire logic [3:0] pwm_out,
  input wire logic cmp1_async_out,
  input wire logic cmp2_async_out,
  // Shutdown sources
  input wire logic logic_cell2_out,
  input wire logic fault_in_n,
  // Outputs to pins
  output var logic output_a,
  output var logic output_a_oe,
  output var logic output_b,
  output var logic output_b_oe
);
  import cwg_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] main_r, main_nxt;
  logic [7:0] src_r, src_nxt;
  logic [7:0] shd_r, shd_nxt;
  logic [5:0] dbr_r, dbr_nxt;
  logic [5:0] dbf_r, dbf_nxt;
  logic [7:0] rdata_nxt;
  logic hold_r, hold_nxt;
  logic shutdown_req;
  logic in_rise;

  always_comb begin
    main_nxt = main_r;
    src_nxt = src_r;
    shd_nxt = shd_r;
    dbr_nxt = dbr_r;
    dbf_nxt = dbf_r;
    rdata_nxt = `CWG_RST_ZERO;
    if (reg_wr) begin
      unique case (reg_addr)
        `CWG_OFF_MAIN: main_nxt = reg_wdata & `CWG_MAIN_MASK;
        `CWG_OFF_SRC: src_nxt = reg_wdata & `CWG_SRC_MASK;
        `CWG_OFF_SHD: shd_nxt = reg_wdata & `CWG_SHD_MASK;
        `CWG_OFF_DBR: dbr_nxt = reg_wdata[`CWG_DB_HI:0];
        `CWG_OFF_DBF: dbf_nxt = reg_wdata[`CWG_DB_HI:0];
        default: ;
      endcase
    end
    // Hardware set wins over a software clear of the status bit
    if (shutdown_req) begin
      shd_nxt[`CWG_ASE_BIT] = 1'b1;
    end else if (shd_r[`CWG_ARS_BIT] && shd_r[`CWG_ASE_BIT]) begin
      shd_nxt[`CWG_ASE_BIT] = 1'b0;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `CWG_OFF_MAIN: rdata_nxt = main_r;
        `CWG_OFF_SRC: rdata_nxt = src_r;
        `CWG_OFF_SHD: rdata_nxt = shd_r;
        `CWG_OFF_DBR: rdata_nxt = {2'h0, dbr_r};
        `CWG_OFF_DBF: rdata_nxt = {2'h0, dbf_r};
        default: rdata_nxt = `CWG_RST_ZERO;
      endcase
    end
  end

  // Counts have no reset so they keep values across resets
  always_ff @(posedge mclk) begin
    dbr_r <= dbr_nxt;
    dbr_r <= dbr_nxt;
    dbf_r <= dbf_nxt;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      main_r <= `CWG_RST_ZERO;
      src_r <= {src_r[7:4], 4'h0}; // levels keep their value
      shd_r <= `CWG_RST_ZERO;
      reg_rdata <= `CWG_RST_ZERO;
    end else begin
      main_r <= main_nxt;
      src_r <= src_nxt;
      shd_r <= shd_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [9:0] sync1_r, sync2_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Idle levels: fault high, sources low, so no false edge after reset
      sync1_r <= 10'h200;
      sync2_r <= 10'h200;
    end else begin
      sync1_r <= {fault_in_n, logic_cell2_out, cmp2_async_out, cmp1_async_out,
                  pwm_out, nco_out, logic_cell1_out};
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------
  // Generator clock
  // ----------------------------------------
  // Fast oscillator modelled as a divided enable; mclk stands for system clock
  logic div_r, div_nxt;
  logic gen_tick;

  always_comb begin
    div_nxt = ~div_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign gen_tick = main_r[`CWG_CS_BIT] ? div_r : 1'b1;

  // ----------------------------------------
  // Source select and shutdown sources
  // ----------------------------------------
  logic src_sel;
  logic src_prev_r, src_prev_nxt;

  always_comb begin
    unique case (src_r[`CWG_IS_HI:`CWG_IS_LO])
      3'h7: src_sel = sync2_r[0];
      3'h6: src_sel = sync2_r[1];
      3'h5: src_sel = sync2_r[5];
      3'h4: src_sel = sync2_r[4];
      3'h3: src_sel = sync2_r[3];
      3'h2: src_sel = sync2_r[2];
      3'h1: src_sel = sync2_r[6];
      3'h0: src_sel = sync2_r[7];
    endcase
  end

  assign shutdown_req = (shd_r[`CWG_C2_BIT] && sync2_r[7])
                     || (shd_r[`CWG_C1_BIT] && sync2_r[6])
                     || (shd_r[`CWG_FLT_BIT] && !sync2_r[9])
                     || (shd_r[`CWG_LC2_BIT] && sync2_r[8]);

  always_comb begin
    src_prev_nxt = src_sel;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_prev_nxt;
    end
  end

  assign in_rise = src_sel && !src_prev_r;

  // ----------------------------------------
  // Shutdown hold
  // ----------------------------------------
  // Overrides persist until the first rising edge after the status clears
  always_comb begin
    hold_nxt = hold_r;
    if (shd_r[`CWG_ASE_BIT]) begin
      hold_nxt = 1'b1;
    end else if (in_rise) begin
      hold_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  // ----------------------------------------
  // Dead-band
  // ----------------------------------------
  logic in_fall;
  logic rise_done, fall_done;
  logic en;

  assign en = main_r[`CWG_ON_BIT];
  assign in_fall = !src_sel && src_prev_r;

  cwg_deadband u_db_rise (
    .mclk(mclk),
    .rst(rst),
    .start(in_rise),
    .abort(in_fall || !en),
    .tick(gen_tick),
    .code(dbr_r),
    .done(rise_done)
  );

  cwg_deadband u_db_fall (
    .mclk(mclk),
    .rst(rst),
    .start(in_fall),
    .abort(in_rise || !en),
    .tick(gen_tick),
    .code(dbf_r),
    .done(fall_done)
  );

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  logic a_nxt, b_nxt, aoe_nxt, boe_nxt;
  logic a_wave, b_wave, active;

  // Pre-delay wave is gated by done, so an edge shorter than the count shows nothing
  assign a_wave = src_sel && rise_done;
  assign b_wave = !src_sel && fall_done;
  assign active = shd_r[`CWG_ASE_BIT] || hold_r;

  always_comb begin
    a_nxt = a_wave ^ main_r[`CWG_POLA_BIT];
    b_nxt = b_wave ^ main_r[`CWG_POLB_BIT];
    aoe_nxt = en && main_r[`CWG_OEA_BIT];
    boe_nxt = en && main_r[`CWG_OEB_BIT];
    if (active) begin
      unique case (cwg_level_t'(src_r[`CWG_LVLA_HI:`CWG_LVLA_LO]))
        CWG_LVL_HIGH: a_nxt = 1'b1;
        CWG_LVL_LOW: a_nxt = 1'b0;
        CWG_LVL_TRI: aoe_nxt = 1'b0;
        CWG_LVL_INACT: a_nxt = main_r[`CWG_POLA_BIT];
      endcase
      unique case (cwg_level_t'(src_r[`CWG_LVLB_HI:`CWG_LVLB_LO]))
        CWG_LVL_HIGH: b_nxt = 1'b1;
        CWG_LVL_LOW: b_nxt = 1'b0;
        CWG_LVL_TRI: boe_nxt = 1'b0;
        CWG_LVL_INACT: b_nxt = main_r[`CWG_POLB_BIT];
      endcase
    end
    if (!en) begin
      a_nxt = 1'b0;
      b_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      output_a <= 1'b0;
      output_b <= 1'b0;
      output_a_oe <= 1'b0;
      output_b_oe <= 1'b0;
    end else begin
      output_a <= a_nxt;
      output_b <= b_nxt;
      output_a_oe <= aoe_nxt;
      output_b_oe <= boe_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_status_sticky: assert property (@(posedge mclk) disable iff (rst)
    shutdown_req |=> shd_r[`CWG_ASE_BIT])
    else $error("status not set by shutdown source");

  a_auto_clear: assert property (@(posedge mclk) disable iff (rst)
    (shd_r[`CWG_ARS_BIT] && shd_r[`CWG_ASE_BIT] && !shutdown_req && !reg_wr)
    |=> !shd_r[`CWG_ASE_BIT])
    else $error("auto restart did not clear status");

  a_off_quiet: assert property (@(posedge mclk) disable iff (rst)
    !en |=> !output_a_oe && !output_b_oe && !output_a && !output_b)
    else $error("outputs active while off");

  a_rise_b_off: assert property (@(posedge mclk) disable iff (rst)
    (in_rise && !active && !main_r[`CWG_POLB_BIT]) |=> !output_b)
    else $error("B not turned off on rising edge");

  a_fall_a_off: assert property (@(posedge mclk) disable iff (rst)
    (in_fall && !active && !main_r[`CWG_POLA_BIT]) |=> !output_a)
    else $error("A not turned off on falling edge");

  a_level_high: assert property (@(posedge mclk) disable iff (rst)
    (active && en && src_r[`CWG_LVLA_HI:`CWG_LVLA_LO] == 2'h3) |=> output_a)
    else $error("A override high not driven");

  a_level_tri: assert property (@(posedge mclk) disable iff (rst)
    (active && src_r[`CWG_LVLB_HI:`CWG_LVLB_LO] == 2'h1) |=> !output_b_oe)
    else $error("B override tristate not applied");

  a_zero_bypass: assert property (@(posedge mclk) disable iff (rst)
    (in_rise && en && dbr_r == 6'h00) |=> rise_done)
    else $error("zero rising count not bypassed");

  a_rd_unimpl: assert property (@(posedge mclk) disable iff (rst)
    (reg_rd && reg_addr == `CWG_OFF_DBR) |=> reg_rdata[7:6] == 2'h0)
    else $error("unimplemented bits read nonzero");

  a_pin_enable: assert property (@(posedge mclk) disable iff (rst)
    (en && !main_r[`CWG_OEA_BIT]) |=> !output_a_oe)
    else $error("A pin driven while disabled");
endmodule

`default_nettype wire

// file: include/cwg_defines.svh
/*
  Register offsets, field positions, reset values and timing figures for the
  complementary waveform generator register block.
  Assumes it is included by bare name from design files.
*/
`ifndef CWG_DEFINES_SVH
`define CWG_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CWG_OFF_MAIN 3'h0
`define CWG_OFF_SRC 3'h1
`define CWG_OFF_SHD 3'h2
`define CWG_OFF_DBR 3'h3
`define CWG_OFF_DBF 3'h4

// ----------------------------------------
// Main control fields
// ----------------------------------------
`define CWG_ON_BIT 7
`define CWG_OEB_BIT 6
`define CWG_OEA_BIT 5
`define CWG_POLB_BIT 4
`define CWG_POLA_BIT 3
`define CWG_CS_BIT 0
`define CWG_MAIN_MASK 8'hf9

// ----------------------------------------
// Source and level fields
// ----------------------------------------
`define CWG_LVLB_HI 7
`define CWG_LVLB_LO 6
`define CWG_LVLA_HI 5
`define CWG_LVLA_LO 4
`define CWG_IS_HI 2
`define CWG_IS_LO 0
`define CWG_SRC_MASK 8'hf7

// ----------------------------------------
// Shutdown control fields
// ----------------------------------------
`define CWG_ASE_BIT 7
`define CWG_ARS_BIT 6
`define CWG_C2_BIT 3
`define CWG_C1_BIT 2
`define CWG_FLT_BIT 1
`define CWG_LC2_BIT 0
`define CWG_SHD_MASK 8'hcf

// ----------------------------------------
// Dead-band fields and reset values
// ----------------------------------------
`define CWG_DB_HI 5
`define CWG_DB_MASK 8'h3f
`define CWG_RST_ZERO 8'h00
`define CWG_DB_ZERO 6'h00
`define CWG_DB_ONE 6'h01
`define CWG_LVL_INACTIVE 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CWG_MCLK_NS 10
`define CWG_FAST_OSC_NS 20
`define CWG_FAST_DIV (`CWG_FAST_OSC_NS / `CWG_MCLK_NS)

`endif

// file: include/cwg_pkg.sv
/*
  Types for the complementary waveform generator.
  Assumes cwg_defines.svh holds all numeric constants.
*/
package cwg_pkg;
  typedef enum logic [1:0] {
    CWG_LVL_INACT,
    CWG_LVL_TRI,
    CWG_LVL_LOW,
    CWG_LVL_HIGH
  } cwg_level_t;

  typedef enum logic [1:0] {
    CWG_ST_IDLE,
    CWG_ST_COUNT,
    CWG_ST_DONE
  } cwg_db_state_t;
endpackage

// file: src/cwg_deadband.sv
/*
  One dead-band delay: after a start pulse it counts generator ticks up to a
  code and then raises done. Raises done on the cycle after start when the code is zero.
  Assumes start and tick come from mclk logic.
*/
`include "cwg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cwg_deadband (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic [5:0] code,
  // Result
  output var logic done
);
  import cwg_pkg::*;

  cwg_db_state_t st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (abort) begin
      st_nxt = CWG_ST_IDLE;
    end else if (start) begin
      cnt_nxt = `CWG_DB_ZERO;
      st_nxt = (code == `CWG_DB_ZERO) ? CWG_ST_DONE : CWG_ST_COUNT;
    end else if (st_r == CWG_ST_COUNT && tick) begin
      cnt_nxt = cnt_r + `CWG_DB_ONE;
      if (cnt_nxt == code) begin
        st_nxt = CWG_ST_DONE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= CWG_ST_IDLE;
      cnt_r <= `CWG_DB_ZERO;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (st_r == CWG_ST_DONE);
endmodule

`default_nettype wire

// file: verification/cwg_switch_model.sv
/*
  Model of the gate drivers behind the two generator output pins.
  Assumes pull-downs on both pins, so a released pin reads low.
*/
`timescale 1ns/1ps
`default_nettype none

module cwg_switch_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pin drive from the generator
  input wire logic output_a,
  input wire logic output_a_oe,
  input wire logic output_b,
  input wire logic output_b_oe,
  // Observed pin state
  output var logic pin_a,
  output var logic pin_b,
  output var logic shoot_seen
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // Pull-down keeps the switch off while a pin floats
  assign pin_a = output_a_oe ? output_a : 1'b0;
  assign pin_b = output_b_oe ? output_b : 1'b0;

  // ----------------------------------------
  // Shoot-through watch
  // ----------------------------------------
  // Both switches on together shorts the supply; sticky until reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      shoot_seen <= 1'b0;
    end else if (pin_a && pin_b) begin
      shoot_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verification/testbench.sv
/*
  Self-checking bench for the complementary waveform generator.
  Assumes normal polarity while the shoot-through watch is read.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic mclk, rst, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, srcs, d;
  logic [3:0] sd;
  logic output_a, output_a_oe, output_b, output_b_oe, pin_a, pin_b, shoot_seen;
  wire logic [7:0] outs = {4'h0, output_b_oe, output_a_oe, output_b, output_a};
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  // Rows: address, write data, read-back
  logic [18:0] rows [14] = '{{3'h0, 8'h7f, 8'h79}, {3'h0, 8'h06, 8'h00},
    {3'h1, 8'hff, 8'hf7}, {3'h1, 8'h0a, 8'h02}, {3'h2, 8'h30, 8'h00},
    {3'h2, 8'h4f, 8'h4f}, {3'h2, 8'h00, 8'h00}, {3'h3, 8'hff, 8'h3f},
    {3'h3, 8'hc2, 8'h02}, {3'h4, 8'hff, 8'h3f}, {3'h4, 8'h03, 8'h03},
    {3'h5, 8'hff, 8'h00}, {3'h7, 8'ha5, 8'h00}, {3'h0, 8'he0, 8'he0}};

  cwg_top u_cwg_top (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .logic_cell1_out(srcs[7]), .nco_out(srcs[6]), .pwm_out(srcs[5:2]),
    .cmp1_async_out(srcs[1] | sd[2]), .cmp2_async_out(srcs[0] | sd[3]),
    .logic_cell2_out(sd[0]), .fault_in_n(~sd[1]),
    .output_a(output_a), .output_a_oe(output_a_oe),
    .output_b(output_b), .output_b_oe(output_b_oe)
  );

  cwg_switch_model u_cwg_switch_model (
    .mclk(mclk), .rst(rst), .output_a(output_a), .output_a_oe(output_a_oe),
    .output_b(output_b), .output_b_oe(output_b_oe),
    .pin_a(pin_a), .pin_b(pin_b), .shoot_seen(shoot_seen)
  );

  // ----------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run needs fewer than a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Settle long enough for synchroniser, short dead bands and output flop
  task automatic src_to(input logic v);
    @(posedge mclk) srcs[2] <= v;
    repeat (10) @(posedge mclk);
  endtask

  // Gap from one output turning off to the other turning on, in mclk cycles
  task automatic db(input logic rise, input int lo, input int hi);
    int t_off = -1;
    int t_on = -1;
    @(posedge mclk) srcs[2] <= rise;
    for (int k = 0; k < 200 && t_on < 0; k++) begin
      @(negedge mclk);
      if (t_off < 0 && (rise ? output_b : output_a) === 1'b0) t_off = k;
      if ((rise ? output_a : output_b) === 1'b1) t_on = k;
    end
    chk({7'h0, t_off >= 0 && t_on - t_off >= lo && t_on - t_off <= hi}, 8'h01);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    srcs = 8'h00;
    sd = 4'h0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(3'h0, d);
    chk(d, 8'h00);
    rd(3'h2, d);
    chk(d, 8'h00);
    rd(3'h1, d);
    chk(d & 8'h0f, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16], d);
      chk(d, rows[i][7:0]);
    end
    src_to(1'b1);
    src_to(1'b0);
    db(1'b1, 2, 3);
    db(1'b0, 3, 4);
    wr(3'h3, 8'h00);
    db(1'b1, 0, 1);
    wr(3'h4, 8'h3f);
    db(1'b0, 63, 64);
    chk({7'h0, shoot_seen}, 8'h00);
    wr(3'h0, 8'he1);
    wr(3'h3, 8'h02);
    db(1'b1, 4, 6);
    wr(3'h0, 8'he8);
    src_to(1'b1);
    chk(outs, 8'h0c);
    wr(3'h0, 8'hf0);
    src_to(1'b1);
    chk(outs, 8'h0f);
    wr(3'h0, 8'hc0);
    src_to(1'b1);
    chk(outs & 8'h0c, 8'h08);
    wr(3'h0, 8'ha0);
    src_to(1'b1);
    chk(outs & 8'h0c, 8'h04);
    wr(3'h0, 8'h60);
    src_to(1'b1);
    chk(outs, 8'h00);
    wr(3'h0, 8'he0);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(3'h1, 8'(c));
      @(posedge mclk) srcs <= 8'h01 << c;
      repeat (10) @(posedge mclk);
      chk(outs, 8'h0d);
      @(posedge mclk) srcs <= 8'h00;
      src_to(1'b0);
      chk(outs, 8'h0e);
    end
    wr(3'h1, 8'he2);
    src_to(1'b1);
    @(posedge mclk) sd <= 4'hf;
    src_to(1'b1);
    rd(3'h2, d);
    chk(d, 8'h00);
    @(posedge mclk) sd <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      wr(3'h2, 8'h01 << i);
      @(posedge mclk) sd[i] <= 1'b1;
      src_to(1'b1);
      rd(3'h2, d);
      chk(d, 8'h80 | (8'h01 << i));
      chk(outs, 8'h0e);
      wr(3'h2, 8'h01 << i);
      rd(3'h2, d);
      chk(d, 8'h80 | (8'h01 << i));
      @(posedge mclk) sd[i] <= 1'b0;
      src_to(1'b1);
      wr(3'h2, 8'h01 << i);
      rd(3'h2, d);
      chk(d, 8'h01 << i);
      chk(outs, 8'h0e);
      src_to(1'b0);
      src_to(1'b1);
      chk(outs, 8'h0d);
    end
    wr(3'h2, 8'h42);
    @(posedge mclk) sd[1] <= 1'b1;
    src_to(1'b1);
    rd(3'h2, d);
    chk(d, 8'hc2);
    @(posedge mclk) sd[1] <= 1'b0;
    src_to(1'b1);
    rd(3'h2, d);
    chk(d, 8'h42);
    chk(outs, 8'h0e);
    src_to(1'b0);
    src_to(1'b1);
    chk(outs, 8'h0d);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h52);
    wr(3'h2, 8'h80);
    rd(3'h2, d);
    chk(d, 8'h80);
    src_to(1'b1);
    chk(outs & 8'h0c, 8'h00);
    wr(3'h1, 8'h02);
    wr(3'h0, 8'he8);
    src_to(1'b1);
    chk(outs, 8'h0d);
    wr(3'h3, 8'h15);
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(3'h3, d);
    chk(d, 8'h15);
    rd(3'h0, d);
    chk(d, 8'h00);
    rd(3'h1, d);
    chk(d, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
